// >>> hw/sltx_pkg.sv
// package for the serial lane transmitter: widths, reset values and types
// assumes a single reference clock samples every link-side signal
`default_nettype none

package sltx_pkg;

	// word and counter geometry
	localparam int unsigned SLTX_WORD_W = 8;
	localparam int unsigned SLTX_CNT_W  = 4;
	localparam logic [SLTX_CNT_W-1:0] SLTX_BITS = 4'h8;
	localparam logic [SLTX_CNT_W-1:0] SLTX_CNT_ONE = 4'h1;
	localparam logic [SLTX_CNT_W-1:0] SLTX_CNT_RST = 4'h0;
	localparam logic [SLTX_WORD_W-1:0] SLTX_WORD_RST = 8'h00;

	// async inputs grouped for synchronisation: 10 control bits plus the word
	localparam int unsigned SLTX_SYNC_W = 10 + SLTX_WORD_W;
	localparam logic [SLTX_SYNC_W-1:0] SLTX_SYNC_RST = 18'h00000;

	// one pad seen from the block: level driven and its enable
	typedef struct packed
	{
		logic out;
		logic oe;
	} sltx_pad_t;

	localparam sltx_pad_t SLTX_PAD_RST = '{out: 1'b0, oe: 1'b0};

	// serializer states
	typedef enum logic [0:0]
	{
		SLTX_IDLE,
		SLTX_SHIFT
	} sltx_state_t;

endpackage

`default_nettype wire

// >>> hw/sltx_lane.sv
// serial lane transmitter: parallel word in, serial bits onto the P/N pad pair
// assumes parallel_clk and serial_clk are slow compared to ref_clk (several samples per half period)
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Core presents an 8-bit word per parallel clock; lane serializes it on serial clock.
// - High-speed data drives the pads only while the high-speed enable is high.
// - Serializer reset, sampled on the parallel clock, returns the serializer to idle.
// - P pad outputs core low-power level, driven only while its enable is high.
// - N pad outputs its own low-power level under its own enable, independent of P.
// - Reversible lane returns each pad's received low-power level to the core.
module sltx_lane
	import sltx_pkg::*;
#(
	parameter bit REVERSIBLE = 1'b1
)
(
	// clock, reset, enable
	input  wire logic                   ref_clk,
	input  wire logic                   rst_b,
	input  wire logic                   ce,
	// link clocks from the pll
	input  wire logic                   parallel_clk,
	input  wire logic                   serial_clk,
	// high-speed core side
	input  wire logic [SLTX_WORD_W-1:0] highspeed_tx_word,
	input  wire logic                   highspeed_drive_en,
	input  wire logic                   serializer_rst,
	// low-power core side
	input  wire logic                   lowpower_pos_out,
	input  wire logic                   lowpower_pos_drive_en,
	input  wire logic                   lowpower_neg_out,
	input  wire logic                   lowpower_neg_drive_en,
	output logic                        lowpower_pos_in,
	output logic                        lowpower_neg_in,
	// pads
	output sltx_pad_t                   pad_p,
	output sltx_pad_t                   pad_n,
	input  wire logic                   pad_p_in,
	input  wire logic                   pad_n_in
);

	////////////////////////////////////////////////////////////////////////
	// synchronisers: every input here is foreign to ref_clk
	logic [SLTX_SYNC_W-1:0] sync1_d, sync1_q, sync2_d, sync2_q;
	logic                   par_prev_d, par_prev_q, ser_prev_d, ser_prev_q;

	// stage one is read by stage two only
	always_comb
	begin
		sync1_d = {parallel_clk, serial_clk, highspeed_drive_en, serializer_rst,
			lowpower_pos_out, lowpower_pos_drive_en, lowpower_neg_out,
			lowpower_neg_drive_en, pad_p_in, pad_n_in, highspeed_tx_word};
		sync2_d = sync1_q;
		par_prev_d = sync2_q[SLTX_SYNC_W-1];
		ser_prev_d = sync2_q[SLTX_SYNC_W-2];
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			sync1_q    <= SLTX_SYNC_RST;
			sync2_q    <= SLTX_SYNC_RST;
			par_prev_q <= 1'b0;
			ser_prev_q <= 1'b0;
		end
		else if (ce)
		begin
			sync1_q    <= sync1_d;
			sync2_q    <= sync2_d;
			par_prev_q <= par_prev_d;
			ser_prev_q <= ser_prev_d;
		end
	end

	// named views of the settled samples
	logic                   par_s, ser_s, hs_en_s, srst_s;
	logic                   lpo_p_s, lpe_p_s, lpo_n_s, lpe_n_s, pin_p_s, pin_n_s;
	logic [SLTX_WORD_W-1:0] word_s;
	logic                   par_rise, ser_rise;

	assign {par_s, ser_s, hs_en_s, srst_s, lpo_p_s, lpe_p_s, lpo_n_s, lpe_n_s,
		pin_p_s, pin_n_s, word_s} = sync2_q;
	assign par_rise = par_s & ~par_prev_q;
	assign ser_rise = ser_s & ~ser_prev_q;

	////////////////////////////////////////////////////////////////////////
	// serializer
	sltx_state_t            state_d, state_q;
	logic [SLTX_WORD_W-1:0] shift_d, shift_q;
	logic [SLTX_CNT_W-1:0]  cnt_d, cnt_q;
	logic                   bit_d, bit_q;

	// a parallel edge wins over a coincident serial edge: it emits bit 0 itself
	always_comb
	begin
		state_d = state_q;
		shift_d = shift_q;
		cnt_d   = cnt_q;
		bit_d   = bit_q;
		if (par_rise && srst_s)
		begin
			state_d = SLTX_IDLE;
			shift_d = SLTX_WORD_RST;
			cnt_d   = SLTX_CNT_RST;
			bit_d   = 1'b0;
		end
		else if (par_rise)
		begin
			state_d = SLTX_SHIFT;
			bit_d   = word_s[0];
			shift_d = {1'b0, word_s[SLTX_WORD_W-1:1]};
			cnt_d   = SLTX_CNT_ONE;
		end
		else
		begin
			case (state_q)
				SLTX_SHIFT:
				begin
					if (ser_rise && cnt_q < SLTX_BITS)
					begin
						bit_d   = shift_q[0];
						shift_d = {1'b0, shift_q[SLTX_WORD_W-1:1]};
						cnt_d   = cnt_q + SLTX_CNT_ONE;
					end
				end
				SLTX_IDLE:
				begin
					bit_d = 1'b0;
				end
				default:
				begin
					state_d = SLTX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			state_q <= SLTX_IDLE;
			shift_q <= SLTX_WORD_RST;
			cnt_q   <= SLTX_CNT_RST;
			bit_q   <= 1'b0;
		end
		else if (ce)
		begin
			state_q <= state_d;
			shift_q <= shift_d;
			cnt_q   <= cnt_d;
			bit_q   <= bit_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pad drive and low-power readback
	sltx_pad_t pad_p_d, pad_p_q, pad_n_d, pad_n_q;
	logic      lp_in_p_d, lp_in_p_q, lp_in_n_d, lp_in_n_q;

	// high-speed drive overrides low-power drive; an idle serializer sends nothing
	always_comb
	begin
		if (hs_en_s && state_q == SLTX_SHIFT)
		begin
			pad_p_d = '{out: bit_q, oe: 1'b1};
			pad_n_d = '{out: ~bit_q, oe: 1'b1};
		end
		else
		begin
			pad_p_d = '{out: lpo_p_s, oe: lpe_p_s};
			pad_n_d = '{out: lpo_n_s, oe: lpe_n_s};
		end
		lp_in_p_d = REVERSIBLE & pin_p_s;
		lp_in_n_d = REVERSIBLE & pin_n_s;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			pad_p_q   <= SLTX_PAD_RST;
			pad_n_q   <= SLTX_PAD_RST;
			lp_in_p_q <= 1'b0;
			lp_in_n_q <= 1'b0;
		end
		else if (ce)
		begin
			pad_p_q   <= pad_p_d;
			pad_n_q   <= pad_n_d;
			lp_in_p_q <= lp_in_p_d;
			lp_in_n_q <= lp_in_n_d;
		end
	end

	assign pad_p           = pad_p_q;
	assign pad_n           = pad_n_q;
	assign lowpower_pos_in = lp_in_p_q;
	assign lowpower_neg_in = lp_in_n_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_load;
		ce && par_rise && !srst_s;
	endsequence

	sequence s_hs_go;
		ce && hs_en_s && state_q == SLTX_SHIFT;
	endsequence

	a_word_capture: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_load |=> bit_q == $past(word_s[0]) && shift_q[SLTX_WORD_W-2:0] == $past(word_s[SLTX_WORD_W-1:1])
			&& cnt_q == SLTX_CNT_ONE)
		else $error("parallel word not captured");

	a_hs_gated: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_hs_go |=> pad_p_q.oe && pad_n_q.oe && pad_p_q.out == $past(bit_q) && pad_n_q.out != pad_p_q.out)
		else $error("high-speed drive wrong");

	a_ser_reset: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ce && par_rise && srst_s |=> state_q == SLTX_IDLE && cnt_q == SLTX_CNT_RST && !bit_q)
		else $error("serializer reset ignored");

	a_lp_p_drive: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ce && !hs_en_s |=> pad_p_q.oe == $past(lpe_p_s) && pad_p_q.out == $past(lpo_p_s))
		else $error("p pad low-power drive wrong");

	a_lp_n_drive: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ce && !hs_en_s |=> pad_n_q.oe == $past(lpe_n_s) && pad_n_q.out == $past(lpo_n_s))
		else $error("n pad low-power drive wrong");

	a_lp_readback: assert property (@(posedge ref_clk) disable iff (!rst_b)
		// the three stages move on the three previous edges, so ce and reset are judged there
		$past(ce) && $past(ce, 2) && $past(ce, 3) && $past(rst_b) && $past(rst_b, 2) && $past(rst_b, 3)
			|-> lowpower_pos_in == (REVERSIBLE & $past(pad_p_in, 3))
			&& lowpower_neg_in == (REVERSIBLE & $past(pad_n_in, 3)))
		else $error("low-power readback wrong");

	a_bit_count: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ce && !par_rise && ser_rise && state_q == SLTX_SHIFT && cnt_q < SLTX_BITS
			|=> cnt_q == $past(cnt_q) + SLTX_CNT_ONE && bit_q == $past(shift_q[0]))
		else $error("serial shift step wrong");

	a_bit_limit: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cnt_q <= SLTX_BITS)
		else $error("more than eight bits shifted");

endmodule

`default_nettype wire

// >>> dv/sltx_core_model.sv
// core side model: one pll source for both lane clocks
// assumes a 20 ns ref_clk; serial 160 ns, parallel every eight serial periods
`timescale 1ns/10ps
`default_nettype none

module sltx_core_model
(
	// clock and frame control
	input  wire logic ref_clk,
	input  wire logic run,
	// pll clocks
	output logic      parallel_clk,
	output logic      serial_clk
);
	logic [5:0] cnt_q = 6'h3f;

	// shared pll source
	// one counter gives both clocks, so edges stay aligned; it parks between frames
	always @(posedge ref_clk)
		cnt_q <= run ? cnt_q + 6'h01 : 6'h3f;

	assign serial_clk   = run & ~cnt_q[2];
	assign parallel_clk = run & ~cnt_q[5];
endmodule

`default_nettype wire

// >>> dv/sltx_lane_test.sv
// testbench for the serial lane transmitter
// assumes the model parks both link clocks low between frames
`timescale 1ns/10ps
`default_nettype none

module sltx_lane_test;
	import sltx_pkg::*;

	logic ref_clk, rst_b, ce, run, pclk, sclk, hs_en, ser_rst;
	logic [7:0] word;
	logic pos_out, pos_en, neg_out, neg_en, pos_in, neg_in, p_in, n_in;
	sltx_pad_t pad_p, pad_n;
	int errors = 0;
	int checks_done = 0;

	sltx_core_model u_sltx_core_model (.ref_clk(ref_clk), .run(run), .parallel_clk(pclk), .serial_clk(sclk));
	sltx_lane u_sltx_lane (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .parallel_clk(pclk), .serial_clk(sclk),
		.highspeed_tx_word(word), .highspeed_drive_en(hs_en), .serializer_rst(ser_rst),
		.lowpower_pos_out(pos_out), .lowpower_pos_drive_en(pos_en), .lowpower_neg_out(neg_out),
		.lowpower_neg_drive_en(neg_en), .lowpower_pos_in(pos_in), .lowpower_neg_in(neg_in),
		.pad_p(pad_p), .pad_n(pad_n), .pad_p_in(p_in), .pad_n_in(n_in));

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic check_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask

	task automatic check_pad(input sltx_pad_t got, input sltx_pad_t exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: pad %b expected %b", $time, got, exp);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic test_lowpower;
		pos_out <= 1'b1; pos_en <= 1'b1; neg_out <= 1'b1; neg_en <= 1'b0;
		tick(4);
		check_pad(pad_p, '{out: 1'b1, oe: 1'b1});
		check_bit(pad_n.oe, 1'b0);
		pos_en <= 1'b0; neg_out <= 1'b0; neg_en <= 1'b1;
		tick(4);
		check_bit(pad_p.oe, 1'b0);
		check_pad(pad_n, '{out: 1'b0, oe: 1'b1});
		$display("test lowpower done");
	endtask

	task automatic test_readback;
		p_in <= 1'b1; n_in <= 1'b0;
		tick(4);
		check_bit(pos_in, 1'b1);
		check_bit(neg_in, 1'b0);
		p_in <= 1'b0; n_in <= 1'b1;
		tick(4);
		check_bit(pos_in, 1'b0);
		check_bit(neg_in, 1'b1);
		$display("test readback done");
	endtask

	// ce low freezes syncs and pads; the enable change lands only once ce returns
	task automatic test_freeze;
		ce <= 1'b0;
		pos_en <= 1'b1;
		tick(6);
		check_bit(pad_p.oe, 1'b0);
		ce <= 1'b1;
		tick(4);
		check_bit(pad_p.oe, 1'b1);
		$display("test freeze done");
	endtask

	// one framed word: bits sampled mid-way through each serial period
	task automatic send_word(input logic [7:0] w);
		word <= w; hs_en <= 1'b1; run <= 1'b1;
		@(posedge pclk);
		tick(8);
		for (int k = 0; k < 8; k++)
		begin
			check_bit(pad_p.out, w[k]);
			check_bit(pad_n.out, ~w[k]);
			check_bit(pad_p.oe, 1'b1);
			if (k < 7)
				tick(8);
		end
		run <= 1'b0;
		tick(4);
	endtask

	task automatic test_highspeed;
		send_word(8'hb4);
		send_word(8'h01);
		send_word(8'h80);
		hs_en <= 1'b0; pos_en <= 1'b1; pos_out <= 1'b0; neg_en <= 1'b0;
		tick(4);
		check_pad(pad_p, '{out: 1'b0, oe: 1'b1});
		check_bit(pad_n.oe, 1'b0);
		$display("test highspeed done");
	endtask

	task automatic test_ser_reset;
		hs_en <= 1'b1; ser_rst <= 1'b1; word <= 8'h55; run <= 1'b1;
		@(posedge pclk);
		tick(8);
		check_pad(pad_p, '{out: 1'b0, oe: 1'b1});
		check_bit(pad_n.oe, 1'b0);
		ser_rst <= 1'b0;
		@(posedge pclk);
		tick(8);
		check_bit(pad_p.out, 1'b1);
		run <= 1'b0;
		tick(4);
		$display("test serializer reset done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// clock, watchdog and main sequence
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	initial
	begin
		#100us;
		errors++;
		give_verdict();
	end

	initial
	begin
		rst_b = 1'b0; ce = 1'b1; run = 1'b0; hs_en = 1'b0; ser_rst = 1'b0; word = 8'h00;
		pos_out = 1'b0; pos_en = 1'b0; neg_out = 1'b0; neg_en = 1'b0; p_in = 1'b0; n_in = 1'b0;
		tick(2);
		rst_b <= 1'b1;
		tick(1);
		check_pad(pad_p, SLTX_PAD_RST);
		check_pad(pad_n, SLTX_PAD_RST);
		test_lowpower();
		test_readback();
		test_freeze();
		test_highspeed();
		test_ser_reset();
		give_verdict();
	end
endmodule

`default_nettype wire
